// *** ssspi_front.sv ***
// ssspi_front: second serial controller, spi personality, master or slave
// assumes pin inputs already synchronous to clk_sys; rate divider counts a
// half period of (lin+1)*2^exp system clocks
//
// Function
// - only spi personality is implemented; other mode values leave it idle
// - each bit period shifts one bit out and samples one bit in together
// - dma and software share the fifos through one stream port pair
// - a data port writes transmit characters and reads received ones
// - pin outputs stay disabled unless the pin function select routes them
// - spi logic runs only while mode select equals two
// - every character is exactly eight bits
// - master generates serial clock, slave takes it from outside
// - master clock rate is programmable, fastest half the reference
// - slave sampling works for external bit rates up to five mhz
// - clock polarity and phase are set by separate bits
// - order bit picks msb first or lsb first for both directions
// - active low slave select input frames transfers in slave role only
// - master select bit picks master role, clear means slave
// - master half period is (linear+1) times two to exponent clocks
// - transmit fifo holds at most three characters, receive fifo holds four
`timescale 1ns/1ps
module ssspi_front
  import ssspi_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // configuration
  input wire logic [1:0] serial_mode_select,
  input wire logic spi_master_select,
  input wire logic clock_polarity_bit,
  input wire logic clock_phase_bit,
  input wire logic bit_order_bit,
  input wire logic [3:0] clock_rate_linear,
  input wire logic [3:0] clock_rate_exponent,
  input wire logic pin_function_select,
  // transmit data stream (software or dma)
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  // receive data stream
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  // status
  output logic tx_idle,
  output logic rx_overflow,
  // pins: output enables are low while driving
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe_n,
  input wire logic serial_clock_pin_i,
  output logic mosi_o,
  output logic mosi_oe_n,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_n,
  input wire logic miso_i,
  input wire logic slave_select_in_n
);
  import ssspi_pkg::*;

  ssspi_state_e st_ff;
  logic spi_en;
  assign spi_en = (serial_mode_select == SSSPI_MODE_SPI);

  // transmit fifo, four entries, at most three filled
  logic [7:0] txq_ff [SSSPI_FIFO_DEPTH];
  logic [1:0] txq_wr_ff, txq_rd_ff;
  logic [2:0] txq_cnt_ff;
  logic txq_pop;
  logic tx_push;
  assign tx_push = tx_valid && tx_ready;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      txq_wr_ff <= 2'h0;
      txq_rd_ff <= 2'h0;
      txq_cnt_ff <= 3'h0;
    end else if (!spi_en) begin
      txq_wr_ff <= 2'h0;
      txq_rd_ff <= 2'h0;
      txq_cnt_ff <= 3'h0;
    end else begin
      if (tx_push) begin
        txq_ff[txq_wr_ff] <= tx_data;
        txq_wr_ff <= txq_wr_ff + 2'h1;
      end
      if (txq_pop) txq_rd_ff <= txq_rd_ff + 2'h1;
      txq_cnt_ff <= txq_cnt_ff + {2'h0, tx_push} - {2'h0, txq_pop};
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tx_ready <= 1'b0;
      tx_idle <= 1'b1;
    end else begin
      tx_ready <= spi_en && (txq_cnt_ff + {2'h0, tx_push} - {2'h0, txq_pop}
                  < 3'(SSSPI_FIFO_DEPTH - 1));
      tx_idle <= (txq_cnt_ff == 3'h0) && (st_ff == SSSPI_ST_IDLE);
    end
  end

  // shift engine
  logic [7:0] sh_out_ff, sh_in_ff;
  logic [2:0] bit_ff;
  // twenty bits, just enough that 16 << 15 does not wrap to zero
  logic [19:0] div_ff;
  logic [19:0] half_cyc;
  logic sck_ff;
  logic sck_d_ff, ssn_d_ff;
  logic done_pulse;
  logic [7:0] done_byte;
  logic shift_bit;
  assign half_cyc = ({16'h0, clock_rate_linear} + 20'h1) << clock_rate_exponent;
  assign shift_bit = bit_order_bit ? sh_out_ff[0] : sh_out_ff[7];

  // slave edges: idle level equals polarity; leading edge leaves it
  logic sl_lead, sl_trail, sl_sel;
  assign sl_sel = !slave_select_in_n;
  assign sl_lead = (serial_clock_pin_i != sck_d_ff) && (serial_clock_pin_i != clock_polarity_bit);
  assign sl_trail = (serial_clock_pin_i != sck_d_ff) && (serial_clock_pin_i == clock_polarity_bit);
  // slave inputs are sampled every system clock, 25 per bit at 5 mhz
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sck_d_ff <= 1'b0;
      ssn_d_ff <= 1'b1;
    end else begin
      sck_d_ff <= serial_clock_pin_i;
      ssn_d_ff <= slave_select_in_n;
    end
  end

  function automatic logic [7:0] ins(input logic [7:0] v, input logic b, input logic lsb);
    ins = lsb ? {b, v[7:1]} : {v[6:0], b};
  endfunction

  logic m_tick, sample_now, shift_now;
  assign m_tick = (div_ff >= half_cyc - 20'h1);
  always_comb begin
    sample_now = 1'b0;
    shift_now = 1'b0;
    if (spi_master_select) begin
      sample_now = m_tick && ((st_ff == SSSPI_ST_LEAD) != clock_phase_bit);
      shift_now = m_tick && ((st_ff == SSSPI_ST_TRAIL) != clock_phase_bit);
    end else if (sl_sel) begin
      sample_now = clock_phase_bit ? sl_trail : sl_lead;
      shift_now = clock_phase_bit ? sl_lead : sl_trail;
    end
  end
  assign txq_pop = spi_en && (st_ff == SSSPI_ST_IDLE) && (txq_cnt_ff != 3'h0)
                   && (spi_master_select || sl_sel);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_ff <= SSSPI_ST_IDLE;
      sh_out_ff <= SSSPI_DATA_RESET;
      sh_in_ff <= SSSPI_DATA_RESET;
      bit_ff <= 3'h0;
      div_ff <= 20'h0;
      sck_ff <= 1'b0;
      done_pulse <= 1'b0;
      done_byte <= SSSPI_DATA_RESET;
    end else begin
      done_pulse <= 1'b0;
      if (!spi_en) begin
        st_ff <= SSSPI_ST_IDLE;
        sck_ff <= clock_polarity_bit;
        div_ff <= 20'h0;
      end else begin
        case (st_ff)
          SSSPI_ST_IDLE: begin
            sck_ff <= clock_polarity_bit;
            div_ff <= 20'h0;
            bit_ff <= 3'h0;
            if (txq_pop) begin
              sh_out_ff <= txq_ff[txq_rd_ff];
              st_ff <= SSSPI_ST_LEAD;
            end
          end
          SSSPI_ST_LEAD, SSSPI_ST_TRAIL: begin
            div_ff <= m_tick ? 20'h0 : div_ff + 20'h1;
            if (spi_master_select && m_tick) begin
              sck_ff <= !sck_ff;
            end
            if (sample_now) begin
              sh_in_ff <= ins(sh_in_ff, spi_master_select ? miso_i : mosi_i,
                              bit_order_bit);
            end
            if (shift_now && (st_ff == SSSPI_ST_TRAIL || clock_phase_bit)) begin
              if (!(clock_phase_bit && st_ff == SSSPI_ST_LEAD && bit_ff == 3'h0))
                sh_out_ff <= bit_order_bit ? {1'b0, sh_out_ff[7:1]} : {sh_out_ff[6:0], 1'b0};
            end
            // in master role the pin input echoes our own clock; ignore it
            if (spi_master_select ? m_tick : (sl_lead || sl_trail)) begin
              if (st_ff == SSSPI_ST_LEAD) st_ff <= SSSPI_ST_TRAIL;
              else if (bit_ff == 3'(SSSPI_WORD_BITS - 1)) st_ff <= SSSPI_ST_DONE;
              else begin
                st_ff <= SSSPI_ST_LEAD;
                bit_ff <= bit_ff + 3'h1;
              end
            end
            // deselect cuts the frame and wins over any edge
            if (!spi_master_select && !sl_sel) st_ff <= SSSPI_ST_IDLE;
          end
          SSSPI_ST_DONE: begin
            done_pulse <= 1'b1;
            done_byte <= sh_in_ff;
            st_ff <= SSSPI_ST_IDLE;
          end
          default: st_ff <= SSSPI_ST_IDLE;
        endcase
      end
    end
  end

  // pin drivers; enables low while driving
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      serial_clock_pin_o <= 1'b0;
      serial_clock_pin_oe_n <= 1'b1;
      mosi_o <= 1'b0;
      mosi_oe_n <= 1'b1;
      miso_o <= 1'b0;
      miso_oe_n <= 1'b1;
    end else begin
      serial_clock_pin_o <= sck_ff;
      mosi_o <= shift_bit;
      miso_o <= shift_bit;
      serial_clock_pin_oe_n <= !(spi_en && pin_function_select && spi_master_select);
      mosi_oe_n <= !(spi_en && pin_function_select && spi_master_select);
      miso_oe_n <= !(spi_en && pin_function_select && !spi_master_select && sl_sel);
    end
  end

  // receive fifo (four deep) then a two-entry skid buffer to the output port
  logic [7:0] rxq_ff [SSSPI_FIFO_DEPTH];
  logic [1:0] rxq_wr_ff, rxq_rd_ff;
  logic [2:0] rxq_cnt_ff;
  logic [7:0] ob_ff [SSSPI_BUF_DEPTH];
  logic ob_wr_ff, ob_rd_ff;
  logic [1:0] ob_cnt_ff;
  logic rxq_push, rxq_pop, ob_pop;
  assign rxq_push = done_pulse && (rxq_cnt_ff != 3'(SSSPI_FIFO_DEPTH));
  assign rxq_pop = spi_en && (rxq_cnt_ff != 3'h0) && (ob_cnt_ff != 2'(SSSPI_BUF_DEPTH));
  assign ob_pop = rx_valid && rx_ready;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rxq_wr_ff <= 2'h0;
      rxq_rd_ff <= 2'h0;
      rxq_cnt_ff <= 3'h0;
      rx_overflow <= 1'b0;
    end else begin
      // leaving spi mode flushes the receive path
      if (!spi_en) begin
        rxq_wr_ff <= 2'h0;
        rxq_rd_ff <= 2'h0;
        rxq_cnt_ff <= 3'h0;
      end else begin
        if (rxq_push) begin
          rxq_ff[rxq_wr_ff] <= done_byte;
          rxq_wr_ff <= rxq_wr_ff + 2'h1;
        end
        if (rxq_pop) rxq_rd_ff <= rxq_rd_ff + 2'h1;
        rxq_cnt_ff <= rxq_cnt_ff + {2'h0, rxq_push} - {2'h0, rxq_pop};
      end
      // overflow is sticky until the mode leaves spi
      if (done_pulse && !rxq_push) rx_overflow <= 1'b1;
      else if (!spi_en) rx_overflow <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ob_wr_ff <= 1'b0;
      ob_rd_ff <= 1'b0;
      ob_cnt_ff <= 2'h0;
      rx_valid <= 1'b0;
      rx_data <= SSSPI_DATA_RESET;
    end else if (!spi_en) begin
      ob_wr_ff <= 1'b0;
      ob_rd_ff <= 1'b0;
      ob_cnt_ff <= 2'h0;
      rx_valid <= 1'b0;
    end else begin
      if (rxq_pop) begin
        ob_ff[ob_wr_ff] <= rxq_ff[rxq_rd_ff];
        ob_wr_ff <= !ob_wr_ff;
      end
      if (ob_pop) ob_rd_ff <= !ob_rd_ff;
      ob_cnt_ff <= ob_cnt_ff + {1'b0, rxq_pop} - {1'b0, ob_pop};
      // output registered from the next head entry
      if (ob_pop) begin
        rx_valid <= (ob_cnt_ff > 2'h1) || rxq_pop;
        rx_data <= (ob_cnt_ff > 2'h1) ? ob_ff[!ob_rd_ff] : rxq_ff[rxq_rd_ff];
      end else if (!rx_valid && rxq_pop) begin
        rx_valid <= 1'b1;
        rx_data <= rxq_ff[rxq_rd_ff];
      end
    end
  end

  // checks
  property p_idle_off;
    @(posedge clk_sys) disable iff (!nrst) !spi_en |=> st_ff == SSSPI_ST_IDLE;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("engine active outside spi mode");
  property p_pins_off;
    @(posedge clk_sys) disable iff (!nrst)
      !pin_function_select |=> serial_clock_pin_oe_n && mosi_oe_n && miso_oe_n;
  endproperty
  a_pins_off: assert property (p_pins_off) else $error("pin driven while not routed");
  property p_rx_cap;
    @(posedge clk_sys) disable iff (!nrst) rxq_cnt_ff <= 3'(SSSPI_FIFO_DEPTH);
  endproperty
  a_rx_cap: assert property (p_rx_cap) else $error("rx fifo above four");
  property p_tx_cap;
    @(posedge clk_sys) disable iff (!nrst) txq_cnt_ff <= 3'(SSSPI_FIFO_DEPTH);
  endproperty
  a_tx_cap: assert property (p_tx_cap) else $error("tx fifo above four");
  property p_ovf;
    @(posedge clk_sys) disable iff (!nrst)
      spi_en && done_pulse && rxq_cnt_ff == 3'(SSSPI_FIFO_DEPTH) |=> rx_overflow;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not flagged");
  property p_done_bits;
    @(posedge clk_sys) disable iff (!nrst)
      $rose(st_ff == SSSPI_ST_DONE) |-> $past(bit_ff) == 3'h7;
  endproperty
  a_done_bits: assert property (p_done_bits) else $error("word not eight bits");
  property p_slave_sel;
    @(posedge clk_sys) disable iff (!nrst)
      spi_en && !spi_master_select && slave_select_in_n
      && (st_ff == SSSPI_ST_LEAD || st_ff == SSSPI_ST_TRAIL) |=> st_ff == SSSPI_ST_IDLE;
  endproperty
  a_slave_sel: assert property (p_slave_sel) else $error("slave ran without select");
  property p_miso_role;
    @(posedge clk_sys) disable iff (!nrst) spi_master_select |=> miso_oe_n;
  endproperty
  a_miso_role: assert property (p_miso_role) else $error("master drove miso");
endmodule

// *** ssspi_pkg.sv ***
// ssspi_pkg: constants shared by the serial spi front
// assumes a single 125 mhz system clock domain
package ssspi_pkg;
  localparam int SSSPI_WORD_BITS = 8;
  localparam int SSSPI_FIFO_DEPTH = 4;
  localparam int SSSPI_BUF_DEPTH = 2;
  localparam logic [1:0] SSSPI_MODE_SPI = 2'h2;
  localparam logic [1:0] SSSPI_MODE_RESET = 2'h0;
  localparam logic [3:0] SSSPI_RATE_RESET = 4'h0;
  localparam logic [7:0] SSSPI_DATA_RESET = 8'h00;
  localparam int SSSPI_CLK_MHZ = 125;
  localparam int SSSPI_SLAVE_MAX_MHZ = 5;
  // slave link bit time in system clocks, rounded down (shortest time)
  localparam int SSSPI_SLAVE_BIT_CYC = SSSPI_CLK_MHZ / SSSPI_SLAVE_MAX_MHZ;
  localparam int SSSPI_PIN_GPIO_SEL = 0;
  typedef enum logic [3:0] {
    SSSPI_ST_IDLE = 4'h1,
    SSSPI_ST_LEAD = 4'h2,
    SSSPI_ST_TRAIL = 4'h4,
    SSSPI_ST_DONE = 4'h8
  } ssspi_state_e;
endpackage

// *** ssspi_slave_model.sv ***
// ssspi_slave_model: external spi slave on the far side of the master role
// assumes pins registered to clk_sys and software selecting it through sel_n
`timescale 1ns/1ps
module ssspi_slave_model (
  // clock and select
  input wire logic clk_sys,
  input wire logic sel_n,
  // link pins
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  // frame format and data
  input wire logic cpol,
  input wire logic cpha,
  input wire logic lsb,
  input wire logic [7:0] reply,
  output logic [7:0] got
);
  logic sck_ff = 1'b0;
  logic last_ff = 1'b0;
  logic [7:0] sr_ff = 8'h00;
  logic [3:0] nsh_ff = 4'h0;
  // released line shows the inverse of the last bit, never a kind stale value
  assign miso = sel_n ? ~last_ff : (lsb ? sr_ff[0] : sr_ff[7]);
  always @(posedge clk_sys) begin
    sck_ff <= sck;
    if (!sel_n) begin
      last_ff <= miso;
    end
    if (sel_n) begin
      sr_ff <= reply;
      nsh_ff <= 4'h0;
    end else if (sck != sck_ff) begin
      if (sck == (cpol ^ !cpha)) begin
        got <= lsb ? {mosi, got[7:1]} : {got[6:0], mosi};
      end else begin
        // phase one: the first leading edge only starts driving, it must not shift
        if (!(cpha && nsh_ff == 4'h0)) begin
          sr_ff <= lsb ? (sr_ff >> 1) : (sr_ff << 1);
        end
        nsh_ff <= nsh_ff + 4'h1;
      end
    end
  end
endmodule

// *** sync_serial_spi_front_tb.sv ***
// sync_serial_spi_front_tb: self-checking bench for the spi front
// assumes the slave model above; bench plays software, dma and external master
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
  $display("BAD %0t got %h exp %h", $time, a, b); end end
module sync_serial_spi_front_tb;
  import ssspi_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] mode = 2'h0;
  logic mst = 1'b1, cpol = 1'b0, cpha = 1'b0, lsb = 1'b0, pinsel = 1'b1;
  logic [3:0] lin = 4'h1, expo = 4'h1;
  logic [7:0] tx_data = 8'h00, reply = 8'h00, rx_data, m_got, s_got, d;
  logic tx_valid = 1'b0, rx_ready = 1'b0, tx_ready, rx_valid, tx_idle, rx_ovf;
  logic sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n, m_miso;
  logic tb_sck = 1'b0, tb_mosi = 1'b0, ss_n = 1'b1, msel_n = 1'b1;
  int error_cnt = 0;
  int n_tests = 0;
  int cnt;
  wire sck_w = sck_oe_n ? tb_sck : sck_o;
  wire mosi_w = mosi_oe_n ? tb_mosi : mosi_o;
  wire miso_w = miso_oe_n ? m_miso : miso_o;
  always #4 clk_sys = ~clk_sys;
  ssspi_front u_dut (.clk_sys(clk_sys), .nrst(nrst), .serial_mode_select(mode),
    .spi_master_select(mst), .clock_polarity_bit(cpol), .clock_phase_bit(cpha),
    .bit_order_bit(lsb), .clock_rate_linear(lin), .clock_rate_exponent(expo),
    .pin_function_select(pinsel), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_idle(tx_idle), .rx_overflow(rx_ovf), .serial_clock_pin_o(sck_o),
    .serial_clock_pin_oe_n(sck_oe_n), .serial_clock_pin_i(sck_w), .mosi_o(mosi_o),
    .mosi_oe_n(mosi_oe_n), .mosi_i(mosi_w), .miso_o(miso_o), .miso_oe_n(miso_oe_n),
    .miso_i(miso_w), .slave_select_in_n(ss_n));
  ssspi_slave_model u_slv (.clk_sys(clk_sys), .sel_n(msel_n), .sck(sck_w), .mosi(mosi_w),
    .miso(m_miso), .cpol(cpol), .cpha(cpha), .lsb(lsb), .reply(reply), .got(m_got));
  task automatic report_and_stop;
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic hang;
    error_cnt++;
    $display("BAD %0t timeout", $time);
    report_and_stop();
  endtask
  task automatic send(input logic [7:0] b);
    int i;
    @(posedge clk_sys);
    tx_data <= b;
    tx_valid <= 1'b1;
    for (i = 0; i < 9000; i++) begin
      @(posedge clk_sys);
      if (tx_ready === 1'b1) break;
    end
    if (i == 9000) hang();
    tx_valid <= 1'b0;
  endtask
  task automatic recv;
    int i;
    @(posedge clk_sys);
    rx_ready <= 1'b1;
    for (i = 0; i < 9000; i++) begin
      @(posedge clk_sys);
      if (rx_valid === 1'b1) break;
    end
    if (i == 9000) hang();
    d = rx_data;
    rx_ready <= 1'b0;
  endtask
  // reconfigure only with spi mode left, so no stale clock edge leaks out
  task automatic setup(input logic [2:0] f, input logic m);
    @(posedge clk_sys);
    mode <= 2'h0;
    tick(2);
    {lsb, cpha, cpol} <= f;
    mst <= m;
    tick(2);
    mode <= SSSPI_MODE_SPI;
    tick(4);
  endtask
  initial begin
    tick(10);
    nrst <= 1'b1;
    tick(3);
    `CHK(tx_ready, 1'b0)
    `CHK(sck_oe_n, 1'b1)
    for (int k = 0; k < 8; k++) begin
      setup(k[2:0], 1'b1);
      `CHK(sck_w, cpol)
      reply <= 8'hb4 - k[7:0];
      tick(1);
      msel_n <= 1'b0;
      send(8'h1d + k[7:0]);
      recv();
      msel_n <= 1'b1;
      `CHK(d, 8'hb4 - k[7:0])
      `CHK(m_got, 8'h1d + k[7:0])
    end
    lin <= 4'h2;
    setup(3'h0, 1'b1);
    msel_n <= 1'b0;
    send(8'ha5);
    for (cnt = 0; cnt < 900 && sck_w === 1'b0; cnt++) @(posedge clk_sys);
    for (cnt = 0; cnt < 900 && sck_w === 1'b1; cnt++) @(posedge clk_sys);
    `CHK(cnt, 6)
    recv();
    `CHK(tx_ready, 1'b1)
    // deselect for two cycles so the far side loads its new reply
    msel_n <= 1'b1;
    reply <= 8'h5a;
    tick(2);
    msel_n <= 1'b0;
    for (int k = 0; k < 8; k++) send(8'h40 + k[7:0]);
    for (cnt = 0; cnt < 9000 && tx_idle !== 1'b1; cnt++) @(posedge clk_sys);
    tick(20);
    `CHK(rx_ovf, 1'b1)
    recv();
    `CHK(d, 8'h5a)
    msel_n <= 1'b1;
    setup(3'h0, 1'b1);
    `CHK(rx_ovf, 1'b0)
    pinsel <= 1'b0;
    tick(3);
    `CHK({sck_oe_n, mosi_oe_n, miso_oe_n}, 3'h7)
    pinsel <= 1'b1;
    // slave role: bench is the external master at 26 clocks a bit, under 5 mhz
    setup(3'h0, 1'b0);
    send(8'h93);
    ss_n <= 1'b0;
    tick(13);
    for (int i = 7; i >= 0; i--) begin
      tb_mosi <= 1'(8'h4e >> i);
      tick(13);
      tb_sck <= 1'b1;
      s_got = {s_got[6:0], miso_w};
      tick(13);
      tb_sck <= 1'b0;
    end
    `CHK(miso_oe_n, 1'b0)
    tick(2);
    ss_n <= 1'b1;
    `CHK(s_got, 8'h93)
    recv();
    `CHK(d, 8'h4e)
    report_and_stop();
  end
endmodule
